/* verilog/tph_pkg.sv */
`default_nettype none
package tph_pkg;

	// Register indices; the byte address of each is four times the index.
	localparam logic [7:0] IDX_DATA_ACCESS = 8'h30;
	localparam logic [7:0] IDX_PKT_STATUS = 8'h31;
	localparam logic [7:0] IDX_HDR_CTRL = 8'h33;
	localparam logic [7:0] IDX_TX_CTRL = 8'h40;
	localparam logic [7:0] IDX_PREAMBLE = 8'h41;
	localparam logic [7:0] IDX_SYNC = 8'h42;
	localparam logic [7:0] IDX_HEADER = 8'h43;
	localparam logic [7:0] IDX_PKT_LEN = 8'h44;
	localparam logic [7:0] IDX_INT_STATUS = 8'h45;
	localparam logic [7:0] IDX_INT_MASK = 8'h46;

	// Values after reset.
	localparam logic [7:0] RST_DATA_ACCESS = 8'h00;
	localparam logic [7:0] RST_HDR_CTRL = 8'h00;
	localparam logic [7:0] RST_PREAMBLE = 8'h08;
	localparam logic [31:0] RST_SYNC = 32'h2D00_0000;
	localparam logic [31:0] RST_HEADER = 32'h0000_0000;
	localparam logic [7:0] RST_PKT_LEN = 8'h00;
	localparam logic [1:0] RST_SRC_MODE = 2'h2;
	localparam logic [1:0] RST_INT = 2'h0;
	localparam logic [15:0] CRC_SEED = 16'hFFFF;

	// Field positions outside the structs.
	localparam int BIT_PKT_TX = 1;
	localparam int BIT_PKT_SENT = 0;
	localparam int BIT_TX_START = 0;
	localparam int INT_SENT = 0;
	localparam int INT_START = 1;

	// Modes, polynomials and counts.
	localparam logic [1:0] SRC_FIFO = 2'h2;
	localparam logic [1:0] CRC_CCITT = 2'h0;
	localparam logic [1:0] CRC_IBM = 2'h1;
	localparam logic [1:0] CRC_IEC = 2'h2;
	localparam logic [15:0] POLY_CCITT = 16'h1021;
	localparam logic [15:0] POLY_IBM = 16'h8005;
	localparam logic [15:0] POLY_IEC = 16'h3D65;
	localparam logic [15:0] POLY_BAICHEVA = 16'hC867;
	localparam logic [3:0] PREAMBLE_NIBBLE = 4'hA;
	localparam logic [2:0] HDR_MAX = 3'h4;
	localparam logic [4:0] BITS_NIBBLE = 5'h04;
	localparam logic [4:0] BITS_BYTE = 5'h08;
	localparam logic [4:0] BITS_CRC = 5'h10;

	typedef struct packed {
		logic rsv7;
		logic lsbFirst;
		logic crcDataOnly;
		logic rsv4;
		logic pktEn;
		logic crcEn;
		logic [1:0] crcSel;
	} tph_dac_s;

	typedef struct packed {
		logic rsv7;
		logic [2:0] hdrLen;
		logic fixLen;
		logic [1:0] syncLen;
		logic preMsb;
	} tph_hdrctl_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PRE,
		ST_SYNC,
		ST_HDR,
		ST_LEN,
		ST_DATA,
		ST_CRC,
		ST_RAW
	} tph_state_e;

endpackage
`default_nettype wire

/* verilog/tph_crc16.sv */
`timescale 1ns/10ps
`default_nettype none
module tph_crc16 (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic shiftEn,
	input wire logic bitIn,
	input wire logic [1:0] polySel,
	output logic [15:0] crc
);

	logic [15:0] crcReg;
	logic [15:0] crcNext;
	wire [15:0] poly;
	wire feedBack;

	assign poly = (polySel == tph_pkg::CRC_CCITT) ? tph_pkg::POLY_CCITT :
		(polySel == tph_pkg::CRC_IBM) ? tph_pkg::POLY_IBM :
		(polySel == tph_pkg::CRC_IEC) ? tph_pkg::POLY_IEC :
		tph_pkg::POLY_BAICHEVA;
	assign feedBack = bitIn ^ crcReg[15];
	assign crcNext = {crcReg[14:0], 1'b0} ^ (feedBack ? poly : 16'h0000);
	assign crc = crcReg;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			crcReg <= tph_pkg::CRC_SEED;
		end else if (clear) begin
			crcReg <= tph_pkg::CRC_SEED;
		end else if (shiftEn) begin
			crcReg <= crcNext;
		end
	end

endmodule
`default_nettype wire

/* verilog/tph_tx_packet.sv */
`timescale 1ns/10ps
`default_nettype none
module tph_tx_packet (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] fifoData,
	input wire logic fifoValid,
	output logic fifoPop,
	input wire logic bitTick,
	output logic txBit,
	output logic txActive,
	output logic irq
);

	function automatic logic regMapped(input logic [7:0] idx);
		regMapped = (idx == tph_pkg::IDX_DATA_ACCESS) ||
			(idx == tph_pkg::IDX_PKT_STATUS) ||
			(idx == tph_pkg::IDX_HDR_CTRL) ||
			(idx == tph_pkg::IDX_TX_CTRL) ||
			(idx == tph_pkg::IDX_PREAMBLE) ||
			(idx == tph_pkg::IDX_SYNC) ||
			(idx == tph_pkg::IDX_HEADER) ||
			(idx == tph_pkg::IDX_PKT_LEN) ||
			(idx == tph_pkg::IDX_INT_STATUS) ||
			(idx == tph_pkg::IDX_INT_MASK);
	endfunction

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		rev8 = r;
	endfunction

	tph_pkg::tph_dac_s dacReg;
	tph_pkg::tph_hdrctl_s hdrCtlReg;
	logic [7:0] preLowReg;
	logic [31:0] syncReg;
	logic [31:0] headerReg;
	logic [7:0] pktLenReg;
	logic [1:0] srcModeReg;
	logic [1:0] intStatusReg;
	logic [1:0] intStatusNext;
	logic [1:0] intMaskReg;
	logic sentReg;
	logic [31:0] prdataReg;
	logic [31:0] rdMux;
	logic preadyReg;
	logic pslverrReg;
	logic irqReg;
	logic fifoPopReg;
	logic txActiveReg;

	tph_pkg::tph_state_e stateReg;
	tph_pkg::tph_state_e stateNext;
	logic [8:0] cntReg;
	logic [8:0] cntNext;
	logic [31:0] wordReg;
	logic [31:0] wordNext;
	logic [15:0] shiftReg;
	logic [4:0] bitsLeftReg;
	logic loadEn;
	logic byteLoad;
	logic [7:0] byteSrc;
	logic [15:0] loadVal;
	logic [4:0] loadBits;
	logic popNext;
	logic finish;
	logic [15:0] crcValue;

	// Bus decode.
	wire [7:0] accIdx = paddr[9:2];
	wire addrOk = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
	wire hit = addrOk && regMapped(accIdx);
	wire setupPh = psel && !penable;
	wire accessPh = psel && penable;
	wire wrEn = accessPh && pwrite && hit;
	wire rdDone = accessPh && !pwrite && hit;
	wire wrDac = wrEn && (accIdx == tph_pkg::IDX_DATA_ACCESS);
	wire wrHdr = wrEn && (accIdx == tph_pkg::IDX_HDR_CTRL);
	wire wrTxCtrl = wrEn && (accIdx == tph_pkg::IDX_TX_CTRL);
	wire wrPre = wrEn && (accIdx == tph_pkg::IDX_PREAMBLE);
	wire wrSync = wrEn && (accIdx == tph_pkg::IDX_SYNC);
	wire wrHead = wrEn && (accIdx == tph_pkg::IDX_HEADER);
	wire wrLen = wrEn && (accIdx == tph_pkg::IDX_PKT_LEN);
	wire wrMask = wrEn && (accIdx == tph_pkg::IDX_INT_MASK);
	wire rdIntStat = rdDone && (accIdx == tph_pkg::IDX_INT_STATUS);

	// Transmit control terms.
	wire busy = (stateReg != tph_pkg::ST_IDLE);
	wire pktMode = dacReg.pktEn && (srcModeReg == tph_pkg::SRC_FIFO);
	wire startGo = wrTxCtrl && pwdata[tph_pkg::BIT_TX_START] && !busy;
	wire [8:0] preLen = {hdrCtlReg.preMsb, preLowReg};
	wire [8:0] preLenEff = (preLen == 9'h000) ? 9'h001 : preLen;
	wire [2:0] hdrCount = (hdrCtlReg.hdrLen > tph_pkg::HDR_MAX) ?
		tph_pkg::HDR_MAX : hdrCtlReg.hdrLen;
	wire step = busy && (bitsLeftReg == 5'h00);
	wire tickShift = busy && bitTick && (bitsLeftReg != 5'h00);
	wire inDataField = (stateReg == tph_pkg::ST_DATA);
	wire inHdrField = (stateReg == tph_pkg::ST_HDR) ||
		(stateReg == tph_pkg::ST_LEN);
	wire crcScope = dacReg.crcEn &&
		(inDataField || (!dacReg.crcDataOnly && inHdrField));
	wire crcFeed = tickShift && crcScope;
	wire [1:0] intSet = {startGo, finish};
	wire [1:0] intClr = rdIntStat ? prdataReg[1:0] : 2'h0;

	// Set wins over the read clear, so an event in the read cycle survives.
	assign intStatusNext = (intStatusReg & ~intClr) | intSet;

	tph_crc16 u_crc (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clear(startGo),
		.shiftEn(crcFeed),
		.bitIn(shiftReg[15]),
		.polySel(dacReg.crcSel),
		.crc(crcValue)
	);

	// Read data is captured in the setup phase so that it leaves a flop.
	always_comb begin
		rdMux = 32'h0000_0000;
		case (accIdx)
		tph_pkg::IDX_DATA_ACCESS: begin
			rdMux[7:0] = dacReg;
		end
		tph_pkg::IDX_PKT_STATUS: begin
			rdMux[tph_pkg::BIT_PKT_TX] = busy;
			rdMux[tph_pkg::BIT_PKT_SENT] = sentReg;
		end
		tph_pkg::IDX_HDR_CTRL: begin
			rdMux[6:0] = hdrCtlReg[6:0];
		end
		tph_pkg::IDX_TX_CTRL: begin
			rdMux[2:1] = srcModeReg;
		end
		tph_pkg::IDX_PREAMBLE: begin
			rdMux[7:0] = preLowReg;
		end
		tph_pkg::IDX_SYNC: begin
			rdMux = syncReg;
		end
		tph_pkg::IDX_HEADER: begin
			rdMux = headerReg;
		end
		tph_pkg::IDX_PKT_LEN: begin
			rdMux[7:0] = pktLenReg;
		end
		tph_pkg::IDX_INT_STATUS: begin
			rdMux[1:0] = intStatusReg;
		end
		tph_pkg::IDX_INT_MASK: begin
			rdMux[1:0] = intMaskReg;
		end
		default: begin
			rdMux = 32'h0000_0000;
		end
		endcase
	end

	// Sequencer. A step with no load moves on to the next field, except a ST_DATA
	// stall on an empty FIFO; a move costs a clock cycle, never a bit period, as ticks are far apart.
	always_comb begin
		stateNext = stateReg;
		cntNext = cntReg;
		wordNext = wordReg;
		loadEn = 1'b0;
		byteLoad = 1'b0;
		byteSrc = 8'h00;
		loadVal = 16'h0000;
		loadBits = 5'h00;
		popNext = 1'b0;
		finish = 1'b0;
		if (startGo) begin
			stateNext = pktMode ? tph_pkg::ST_PRE : tph_pkg::ST_RAW;
			cntNext = preLenEff;
		end else if (step) begin
			case (stateReg)
			tph_pkg::ST_PRE: begin
				if (cntReg != 9'h000) begin
					loadEn = 1'b1;
					loadVal = {tph_pkg::PREAMBLE_NIBBLE, 12'h000};
					loadBits = tph_pkg::BITS_NIBBLE;
					cntNext = cntReg - 9'h001;
				end else begin
					stateNext = tph_pkg::ST_SYNC;
					wordNext = syncReg;
					cntNext = 9'(hdrCtlReg.syncLen) + 9'h001;
				end
			end
			tph_pkg::ST_SYNC, tph_pkg::ST_HDR: begin
				if (cntReg != 9'h000) begin
					byteLoad = 1'b1;
					byteSrc = wordReg[31:24];
					wordNext = {wordReg[23:0], 8'h00};
					cntNext = cntReg - 9'h001;
				end else if (stateReg == tph_pkg::ST_SYNC) begin
					stateNext = tph_pkg::ST_HDR;
					wordNext = headerReg;
					cntNext = 9'(hdrCount);
				end else begin
					stateNext = tph_pkg::ST_LEN;
					cntNext = hdrCtlReg.fixLen ? 9'h000 : 9'h001;
				end
			end
			tph_pkg::ST_LEN: begin
				if (cntReg != 9'h000) begin
					byteLoad = 1'b1;
					byteSrc = pktLenReg;
					cntNext = 9'h000;
				end else begin
					stateNext = tph_pkg::ST_DATA;
					cntNext = 9'(pktLenReg);
				end
			end
			tph_pkg::ST_DATA: begin
				if (cntReg != 9'h000) begin
					// A short FIFO stalls the packet rather than padding it.
					if (fifoValid) begin
						byteLoad = 1'b1;
						byteSrc = fifoData;
						popNext = 1'b1;
						cntNext = cntReg - 9'h001;
					end
				end else begin
					stateNext = tph_pkg::ST_CRC;
					cntNext = dacReg.crcEn ? 9'h001 : 9'h000;
				end
			end
			tph_pkg::ST_CRC: begin
				if (cntReg != 9'h000) begin
					loadEn = 1'b1;
					loadVal = crcValue;
					loadBits = tph_pkg::BITS_CRC;
					cntNext = 9'h000;
				end else begin
					stateNext = tph_pkg::ST_IDLE;
					finish = 1'b1;
				end
			end
			tph_pkg::ST_RAW: begin
				// Raw mode ends as soon as the FIFO runs dry.
				if (fifoValid) begin
					byteLoad = 1'b1;
					byteSrc = fifoData;
					popNext = 1'b1;
				end else begin
					stateNext = tph_pkg::ST_IDLE;
					finish = 1'b1;
				end
			end
			default: begin
				stateNext = tph_pkg::ST_IDLE;
			end
			endcase
			if (byteLoad) begin
				loadEn = 1'b1;
				loadVal = {dacReg.lsbFirst ? rev8(byteSrc) : byteSrc,
					8'h00};
				loadBits = tph_pkg::BITS_BYTE;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dacReg <= tph_pkg::RST_DATA_ACCESS;
			hdrCtlReg <= tph_pkg::RST_HDR_CTRL;
			preLowReg <= tph_pkg::RST_PREAMBLE;
			syncReg <= tph_pkg::RST_SYNC;
			headerReg <= tph_pkg::RST_HEADER;
			pktLenReg <= tph_pkg::RST_PKT_LEN;
			srcModeReg <= tph_pkg::RST_SRC_MODE;
			intMaskReg <= tph_pkg::RST_INT;
		end else begin
			if (wrDac) dacReg <= pwdata[7:0];
			if (wrHdr) hdrCtlReg <= {1'b0, pwdata[6:0]};
			if (wrPre) preLowReg <= pwdata[7:0];
			if (wrSync) syncReg <= pwdata;
			if (wrHead) headerReg <= pwdata;
			if (wrLen) pktLenReg <= pwdata[7:0];
			if (wrTxCtrl) srcModeReg <= pwdata[2:1];
			if (wrMask) intMaskReg <= pwdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdataReg <= 32'h0000_0000;
			preadyReg <= 1'b0;
			pslverrReg <= 1'b0;
		end else begin
			preadyReg <= 1'b1;
			if (setupPh) begin
				prdataReg <= pwrite ? 32'h0000_0000 : rdMux;
				pslverrReg <= !hit;
			end
		end
	end

	// Only the interrupt status read clears events; the packet status
	// register shows the sent flag without touching them.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			intStatusReg <= tph_pkg::RST_INT;
			irqReg <= 1'b0;
			sentReg <= 1'b0;
		end else begin
			intStatusReg <= intStatusNext;
			irqReg <= |(intStatusNext & intMaskReg);
			if (finish) sentReg <= 1'b1;
			else if (startGo) sentReg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stateReg <= tph_pkg::ST_IDLE;
			cntReg <= 9'h000;
			wordReg <= 32'h0000_0000;
			fifoPopReg <= 1'b0;
			txActiveReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			cntReg <= cntNext;
			wordReg <= wordNext;
			fifoPopReg <= popNext;
			txActiveReg <= (stateNext != tph_pkg::ST_IDLE);
		end
	end

	// The last bit of a unit is held, not shifted, so the line keeps it
	// until the next unit is loaded or finish clears the register.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shiftReg <= 16'h0000;
			bitsLeftReg <= 5'h00;
		end else if (loadEn) begin
			shiftReg <= loadVal;
			bitsLeftReg <= loadBits;
		end else if (finish) begin
			shiftReg <= 16'h0000;
		end else if (tickShift) begin
			bitsLeftReg <= bitsLeftReg - 5'h01;
			if (bitsLeftReg != 5'h01) shiftReg <= {shiftReg[14:0], 1'b0};
		end
	end

	assign prdata = prdataReg;
	assign pready = preadyReg;
	assign pslverr = pslverrReg;
	assign fifoPop = fifoPopReg;
	assign txBit = shiftReg[15];
	assign txActive = txActiveReg;
	assign irq = irqReg;

endmodule
`default_nettype wire

/* sim/tph_tx_packet_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module tph_tx_packet_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic fifoPop,
	input wire logic bitTick,
	input wire logic txBit,
	input wire logic txActive,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_pready_up: assert property ($past(reset_n) |-> pready)
		else $error("pready low after reset");
	a_err_bad: assert property (psel && penable && paddr[1:0] != 2'h0
		|-> pslverr) else $error("misaligned access without error");
	a_err_ok: assert property (psel && penable && paddr == 12'h0C0
		|-> !pslverr) else $error("error on mapped register");
	a_status_busy: assert property (
		psel && !penable && !pwrite && paddr == 12'h0C4
		|=> prdata[1] == $past(txActive)) else $error("busy flag wrong");
	a_irq_kept: assert property (
		irq && psel && penable && !pwrite && paddr == 12'h0C4 |=> irq)
		else $error("status read dropped irq");
	a_start_act: assert property (
		psel && penable && pwrite && paddr == 12'h100 && pwdata[0]
		|-> ##[1:2] txActive) else $error("start not taken");
	a_bit_hold: assert property (
		(txActive && !bitTick)[*6] |=> $stable(txBit))
		else $error("bit changed without tick");
	a_idle_zero: assert property (!txActive[*3] |-> !txBit)
		else $error("bit high while idle");
	a_pop_pulse: assert property (fifoPop |-> txActive
		&& !$past(fifoPop)) else $error("bad fifo pop");
endmodule
bind tph_tx_packet tph_tx_packet_chk CHK (.clk_sys(clk_sys),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .fifoPop(fifoPop), .bitTick(bitTick),
	.txBit(txBit), .txActive(txActive), .irq(irq));
`default_nettype wire

/* sim/tph_mod_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tph_mod_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic txBit,
	input wire logic txActive,
	input wire logic fifoPop,
	input wire logic [7:0] gap,
	output logic [7:0] fifoData,
	output logic fifoValid,
	output logic bitTick,
	output logic bitSeen,
	output logic bitVal
);
	logic [7:0] fifoQ[$];
	logic [7:0] cnt;
	// An empty FIFO shows a changing pattern so stale data cannot pass.
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 8'h00;
			bitTick <= 1'b0;
			bitSeen <= 1'b0;
			bitVal <= 1'b0;
			fifoValid <= 1'b0;
			fifoData <= 8'h5A;
		end else begin
			if (fifoPop && fifoQ.size() > 0)
				void'(fifoQ.pop_front());
			fifoValid <= fifoQ.size() > 0;
			fifoData <= fifoQ.size() > 0 ? fifoQ[0] : ~fifoData;
			bitTick <= 1'b0;
			bitSeen <= 1'b0;
			if (!txActive)
				cnt <= 8'h00;
			else if (cnt + 8'h01 >= gap) begin
				cnt <= 8'h00;
				bitTick <= 1'b1;
				bitSeen <= 1'b1;
				bitVal <= txBit;
			end else
				cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// Later cases cover every polynomial, both checksum scopes and a
	// preamble count that needs the ninth length bit.
	localparam logic [7:0] DAC_T[7] = '{8'h48, 8'h08, 8'h44, 8'h2C,
		8'h4D, 8'h0E, 8'h0F};
	localparam logic [7:0] HC_T[7] = '{8'h10, 8'h4E, 8'h00, 8'h20,
		8'h12, 8'h08, 8'h31};
	localparam logic [7:0] PRE_T[7] = '{8'h00, 8'h03, 8'h00, 8'h02,
		8'h05, 8'h01, 8'h00};
	localparam logic [7:0] LEN_T[7] = '{8'h02, 8'h00, 8'h00, 8'h03,
		8'h01, 8'h02, 8'h01};
	localparam logic [7:0] GAP_T[7] = '{8'h06, 8'h0B, 8'h07, 8'h09,
		8'h08, 8'h06, 8'h06};
	logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdVal, sync, hdr;
	logic fifoPop, fifoValid, bitTick, txBit, txActive, irq;
	logic bitSeen, bitVal, errVal, lsb, crcOn, crcEn;
	logic [15:0] crcExp, crcPoly;
	logic [7:0] fifoData, gap, b;
	logic expQ[$];
	int errTotal, testsRun, cyc, seed, n, hn, nb;

	tph_tx_packet DUT (.clk_sys(clk_sys), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fifoData(fifoData), .fifoValid(fifoValid),
		.fifoPop(fifoPop), .bitTick(bitTick), .txBit(txBit),
		.txActive(txActive), .irq(irq));
	tph_mod_model MOD (.clk_sys(clk_sys), .reset_n(reset_n),
		.txBit(txBit), .txActive(txActive), .fifoPop(fifoPop), .gap(gap),
		.fifoData(fifoData), .fifoValid(fifoValid), .bitTick(bitTick),
		.bitSeen(bitSeen), .bitVal(bitVal));

	task testDone;
		if (errTotal == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] want);
		testsRun++;
		if (seen !== want) begin
			errTotal++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Each expected bit also runs through the checksum while it is in scope.
	task pushB(input logic [7:0] v, input int w, input logic l);
		logic x;
		for (int i = 0; i < w; i++) begin
			x = l ? v[i] : v[w - 1 - i];
			expQ.push_back(x);
			if (crcOn)
				crcExp = {crcExp[14:0], 1'b0} ^
					((x ^ crcExp[15]) ? crcPoly : 16'h0000);
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Bits are judged in the order the modulator consumed them.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			errTotal++;
			testDone();
		end
		if (bitSeen && expQ.size() == 0)
			check(bitVal, 1'bx);
		else if (bitSeen)
			check(bitVal, expQ.pop_front());
	end

	initial begin
		seed = 75;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		gap = 8'h06;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		apb(0, 12'h0C0, 0);
		check(rdVal, 32'h0000_0000);
		apb(0, 12'h3FC, 0);
		check(errVal, 1'b1);
		apb(0, 12'h0C2, 0);
		check(errVal, 1'b1);
		apb(1, 12'h0CC, 32'h0000_00FF);
		apb(0, 12'h0CC, 0);
		check(rdVal, 32'h0000_007F);
		for (int k = 0; k < 7; k++) begin
			gap <= GAP_T[k];
			sync = $random(seed);
			hdr = $random(seed);
			lsb = DAC_T[k][6];
			crcEn = DAC_T[k][3] && DAC_T[k][2];
			crcExp = tph_pkg::CRC_SEED;
			crcOn = 1'b0;
			case (DAC_T[k][1:0])
			2'h0: crcPoly = tph_pkg::POLY_CCITT;
			2'h1: crcPoly = tph_pkg::POLY_IBM;
			2'h2: crcPoly = tph_pkg::POLY_IEC;
			default: crcPoly = tph_pkg::POLY_BAICHEVA;
			endcase
			apb(1, 12'h0C0, DAC_T[k]);
			apb(1, 12'h0CC, HC_T[k]);
			apb(1, 12'h104, PRE_T[k]);
			apb(1, 12'h108, sync);
			apb(1, 12'h10C, hdr);
			apb(1, 12'h110, LEN_T[k]);
			apb(1, 12'h118, k == 0);
			n = {HC_T[k][0], PRE_T[k]};
			hn = HC_T[k][6:4] > 4 ? 4 : HC_T[k][6:4];
			nb = DAC_T[k][3] ? LEN_T[k] : 3;
			if (DAC_T[k][3]) begin
				repeat (n == 0 ? 1 : n) pushB(8'h0A, 4, 0);
				for (int j = 0; j <= HC_T[k][2:1]; j++)
					pushB(sync[8 * (3 - j) +: 8], 8, lsb);
				crcOn = crcEn && !DAC_T[k][5];
				for (int j = 0; j < hn; j++)
					pushB(hdr[8 * (3 - j) +: 8], 8, lsb);
				if (!HC_T[k][3])
					pushB(LEN_T[k], 8, lsb);
			end
			crcOn = crcEn;
			for (int j = 0; j < nb; j++) begin
				b = $random(seed);
				MOD.fifoQ.push_back(b);
				pushB(b, 8, lsb);
			end
			crcOn = 1'b0;
			if (crcEn) begin
				pushB(crcExp[15:8], 8, 0);
				pushB(crcExp[7:0], 8, 0);
			end
			apb(1, 12'h100, 32'h0000_0005);
			apb(0, 12'h0C4, 0);
			check(rdVal, 32'h0000_0002);
			for (int t = 0; t < 20000 && txActive === 1'b1; t++)
				@(posedge clk_sys);
			repeat (2) @(posedge clk_sys);
			check(expQ.size(), 0);
			apb(0, 12'h0C4, 0);
			check(rdVal, 32'h0000_0001);
			check(irq, k == 0);
			apb(0, 12'h114, 0);
			check(rdVal, 32'h0000_0003);
			repeat (2) @(posedge clk_sys);
			check(irq, 1'b0);
		end
		testDone();
	end
endmodule
`default_nettype wire
